// *** pkg/fpr_defines.svh ***
// named offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the drive and top design files
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH
// register indices; byte address is four times the index
`define FPR_IDX_RATE_R1   7'h5F
`define FPR_IDX_RATE_LOC  7'h60
`define FPR_IDX_RATE_R2   7'h61
`define FPR_IDX_REMOTE1_RAMP_RATE     7'h62
`define FPR_IDX_CTRL      7'h70
`define FPR_IDX_SRC0      7'h71
`define FPR_IDX_MIN0      7'h74
`define FPR_IDX_MAN0      7'h77
`define FPR_IDX_DUTY0     7'h7A
// field positions
`define FPR_RATE_LSB      0
`define FPR_FAST_BIT      3
`define FPR_RANGE_LSB     4
`define FPR_RAMP_LSB      0
`define FPR_SMOOTH_BIT    3
`define FPR_SYNC_BIT      4
`define FPR_FLOOR_LSB     5
`define FPR_LOCK_BIT      0
`define FPR_SLOW_BIT      1
// reset values
`define FPR_RATE_RST      8'hC4
`define FPR_REMOTE1_RAMP_RATE_RST     8'h00
`define FPR_SRC_RST       3'h4
`define FPR_MIN_RST       8'h80
`define FPR_MAN_RST       8'h00
// timing: sweep times in tenths of a second, low rates in tenths of a hertz, fast rate in hertz
`define FPR_CLK_HZ        125000000
`define FPR_SWEEP_FAST_DS 375
`define FPR_SWEEP_SLOW_DS 522
`define FPR_DUTY_STEPS    255
`define FPR_TOP_RATE_DHZ  882
`define FPR_PWM_STEPS     256
`define FPR_HF_HZ         25000
`endif

// *** pkg/fpr_pkg.sv ***
// types and lookup tables shared by the drive-rate block
// assumes nothing beyond the defines header
package fpr_pkg;
  typedef enum logic [2:0] {
    FPR_SRC_REMOTE1 = 3'h0,
    FPR_SRC_LOCAL   = 3'h1,
    FPR_SRC_REMOTE2 = 3'h2,
    FPR_SRC_FULL    = 3'h3,
    FPR_SRC_OFF     = 3'h4,
    FPR_SRC_MAX_LR  = 3'h5,
    FPR_SRC_MAX_ALL = 3'h6,
    FPR_SRC_MANUAL  = 3'h7
  } fpr_src_t;
  typedef logic [7:0] fpr_duty_t;

  // duty steps per time slot for a ramp code
  function automatic fpr_duty_t fpr_ramp_step(input logic [2:0] code);
    fpr_duty_t tbl [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                           8'h08, 8'h0C, 8'h18, 8'h30};
    return tbl[code];
  endfunction

  // base ticks per pwm step; base tick runs at twice the top rate times 256 period steps
  function automatic logic [4:0] fpr_rate_div(input logic [2:0] code);
    logic [4:0] tbl [8] = '{5'h10, 5'h0C, 5'h08, 5'h06,
                            5'h05, 5'h04, 5'h03, 5'h02};
    return tbl[code];
  endfunction

  // duty sweep span in hundredths of a degree for a range code
  function automatic logic [15:0] fpr_span_cdeg(input logic [3:0] code);
    logic [15:0] tbl [16] = '{16'h00C8, 16'h00FA, 16'h014D, 16'h0190,
                              16'h01F4, 16'h029B, 16'h0320, 16'h03E8,
                              16'h0535, 16'h0640, 16'h07D0, 16'h0A6B,
                              16'h0C80, 16'h0FA0, 16'h14D5, 16'h1F40};
    return tbl[code];
  endfunction
endpackage

// *** pkg/fpr_cfg_if.sv ***
// settings and ticks handed from the register block to one drive
// assumes one instance per fan output
`timescale 1ns/1ps
interface fpr_cfg_if;
  logic [2:0] rate_sel;
  logic       fast_sel;
  logic       smooth_on;
  logic [2:0] ramp_code;
  logic       slot_tick;
  logic       base_tick;
  logic       hf_tick;
  logic [7:0] target;
  logic [7:0] duty;
  modport ctl (output rate_sel, fast_sel, smooth_on, ramp_code,
               slot_tick, base_tick, hf_tick, target, input duty);
  modport drive (input rate_sel, fast_sel, smooth_on, ramp_code,
                 slot_tick, base_tick, hf_tick, target, output duty);
endinterface

// *** src/fpr_drive.sv ***
// one fan output: duty ramp limiter and pwm waveform generator
// assumes ticks are one-cycle pulses from the register block
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_drive
  import fpr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // settings
  fpr_cfg_if.drive  cfg,
  // waveform
  output logic      pwm_o
);
  initial if (CNT_W != 8) $error("fpr_drive: CNT_W must be 8");

  logic [4:0]      pre;
  logic [CNT_W-1:0] cnt;
  logic            step_en;
  logic [7:0]      step;

  assign step = fpr_ramp_step(cfg.ramp_code);

  // duty follows target, or crawls toward it one slot at a time
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg.duty <= 8'h00;
    end else if (!cfg.smooth_on) begin
      cfg.duty <= cfg.target;
    end else if (cfg.slot_tick) begin
      if (cfg.target > cfg.duty) begin
        cfg.duty <= (cfg.target - cfg.duty > step) ?
                    8'(cfg.duty + step) : cfg.target;
      end else if (cfg.target < cfg.duty) begin
        cfg.duty <= (cfg.duty - cfg.target > step) ?
                    8'(cfg.duty - step) : cfg.target;
      end
    end
  end

  // prescaler picks one of eight low rates; fast mode bypasses it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || cfg.fast_sel) begin
      pre <= 5'h00;
    end else if (cfg.base_tick) begin
      pre <= (pre >= 5'(fpr_rate_div(cfg.rate_sel) - 5'h01)) ?
             5'h00 : 5'(pre + 5'h01);
    end
  end

  assign step_en = cfg.fast_sel ? cfg.hf_tick :
                   (cfg.base_tick &&
                    pre >= 5'(fpr_rate_div(cfg.rate_sel) - 5'h01));

  // period counter and compare; full scale forces a steady high
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt   <= '0;
      pwm_o <= 1'b0;
    end else begin
      if (step_en)
        cnt <= CNT_W'(cnt + 1'b1);
      pwm_o <= (cfg.duty == 8'hFF) || (cnt < cfg.duty);
    end
  end
endmodule

// *** src/fpr_tick.sv ***
// free-running divider giving a one-cycle enable every DIV cycles
// assumes DIV of at least one
`timescale 1ns/1ps
module fpr_tick #(
  parameter int unsigned DIV_A = 2,
  parameter int unsigned DIV_B = 2
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // choose the second period
  input  wire logic sel_b_i,
  // enable pulse
  output logic      tick_o
);
  initial if (DIV_A < 1 || DIV_B < 1) $error("fpr_tick: DIV below one");

  logic [31:0] cnt;
  logic [31:0] last;

  assign last = sel_b_i ? 32'(DIV_B - 1) : 32'(DIV_A - 1);

  // counter restarts on wrap; a period change takes effect at once
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt    <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt >= last);
      cnt    <= (cnt >= last) ? 32'h0000_0000 : cnt + 32'h0000_0001;
    end
  end
endmodule

// *** src/fpr_top.sv ***
// fan drive rate, range and acoustic smoothing configuration block
// assumes an apb master on the clock domain and upstream duty logic
// Summary of operation
// - three-bit rate field picks one of eight low rates, 35.3 Hz default
// - bit 3 selects fast drive for 4-wire fans, 3-wire extras ignored
// - upper nibble picks the temperature span of the duty slope
// - once lock is set, writes to the rate registers are ignored
// - a remote-1 governed output ramps toward new duty while smoothing is enabled, else it jumps
// - ramp codes give 1 to 48 steps per slot; slot length from slow bit
// - remote-1 ramp limiting only while smoothing enable bit is 1
// - bit 4 syncs speed inputs two, three, four to output three
// - bit 5 picks zero or minimum duty for output 1 below threshold
// - bit 6 picks zero or minimum duty for output 2 below threshold
// - source field picks controlling temperature or fixed mode
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_top
  import fpr_pkg::*;
#(
  parameter int unsigned SLOT_FAST_CYC = int'(
    64'(`FPR_SWEEP_FAST_DS) * 64'(`FPR_CLK_HZ) /
    64'(10 * `FPR_DUTY_STEPS)),
  parameter int unsigned SLOT_SLOW_CYC = int'(
    64'(`FPR_SWEEP_SLOW_DS) * 64'(`FPR_CLK_HZ) /
    64'(10 * `FPR_DUTY_STEPS)),
  parameter int unsigned BASE_CYC = `FPR_CLK_HZ * 10 /
    (`FPR_TOP_RATE_DHZ * `FPR_PWM_STEPS * 2),
  parameter int unsigned HF_CYC = `FPR_CLK_HZ /
    (`FPR_HF_HZ * `FPR_PWM_STEPS),
  parameter int          ADDR_W = 10
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // per temperature channel: remote 1, local, remote 2
  input  wire logic [2:0][7:0]   auto_duty_i,
  input  wire logic [2:0]        below_min_i,
  // fan drive outputs
  output logic                   fan_drive_one_o,
  output logic                   fan_drive_two_o,
  output logic                   fan_drive_three_o,
  // speed measurement sync to output three
  output logic                   speed_sync_o,
  // slope span per channel, hundredths of a degree
  output logic [2:0][15:0]       range_span_o,
  // lock state
  output logic                   lock_o
);
  localparam int NCH = 3;

  initial begin
    if (ADDR_W < 10)
      $error("fpr_top: ADDR_W too small for the map");
    if (SLOT_FAST_CYC < 1 || SLOT_SLOW_CYC < 1 || BASE_CYC < 1 ||
        HF_CYC < 1)
      $error("fpr_top: divider count below one");
  end

  // register storage
  logic [NCH-1:0][7:0] rate_reg;
  logic [7:0]          remote1_ramp_rate;
  logic                lock;
  logic                slow_sel;
  fpr_src_t            src_reg  [NCH];
  logic [NCH-1:0][7:0] min_reg;
  logic [NCH-1:0][7:0] man_reg;

  // per-output working signals
  logic [NCH-1:0][7:0] next_target;
  logic [NCH-1:0][7:0] target;
  logic [NCH-1:0][7:0] duty;
  logic [NCH-1:0]      pwm;

  // bus decode
  logic [6:0]          idx;
  logic                aligned;
  logic                hit;
  logic                wr_go;
  logic [31:0]         next_rdata;
  logic                next_hit;

  // shared enables
  logic                slot_tick;
  logic                base_tick;
  logic                hf_tick;

  assign idx     = paddr_i[8:2];
  assign aligned = (paddr_i[1:0] == 2'b00) &&
                   (paddr_i[ADDR_W-1:9] == '0);
  assign wr_go   = psel_i && penable_i && pready_o && pwrite_i && hit;

  // map lookup and read data, one cycle before the answer
  always_comb begin
    next_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    case (idx)
      `FPR_IDX_RATE_R1:  next_rdata[7:0] = rate_reg[0];
      `FPR_IDX_RATE_LOC: next_rdata[7:0] = rate_reg[1];
      `FPR_IDX_RATE_R2:  next_rdata[7:0] = rate_reg[2];
      `FPR_IDX_REMOTE1_RAMP_RATE:    next_rdata[7:0] = remote1_ramp_rate;
      `FPR_IDX_CTRL: begin
        next_rdata[`FPR_LOCK_BIT] = lock;
        next_rdata[`FPR_SLOW_BIT] = slow_sel;
      end
      default: begin
        next_hit = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (idx == 7'(`FPR_IDX_SRC0 + i)) begin
            next_hit = 1'b1;
            next_rdata[2:0] = src_reg[i];
          end
          if (idx == 7'(`FPR_IDX_MIN0 + i)) begin
            next_hit = 1'b1;
            next_rdata[7:0] = min_reg[i];
          end
          if (idx == 7'(`FPR_IDX_MAN0 + i)) begin
            next_hit = 1'b1;
            next_rdata[7:0] = man_reg[i];
          end
          if (idx == 7'(`FPR_IDX_DUTY0 + i)) begin
            next_hit = 1'b1;
            next_rdata[7:0] = duty[i];
          end
        end
      end
    endcase
    if (!aligned) begin
      next_hit   = 1'b0;
      next_rdata = 32'h0000_0000;
    end
  end

  // one wait state: the first access cycle loads the answer
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      hit       <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= !next_hit;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      hit       <= next_hit;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      hit       <= 1'b0;
    end
  end

  // rate/range registers; frozen for good once lock is set
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rate_reg <= {NCH{`FPR_RATE_RST}};
    end else if (wr_go && !lock) begin
      for (int i = 0; i < NCH; i++)
        if (idx == 7'(`FPR_IDX_RATE_R1 + i))
          rate_reg[i] <= pwdata_i[7:0];
    end
  end

  // first acoustics register, also frozen by lock
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      remote1_ramp_rate <= `FPR_REMOTE1_RAMP_RATE_RST;
    else if (wr_go && !lock && idx == `FPR_IDX_REMOTE1_RAMP_RATE)
      remote1_ramp_rate <= pwdata_i[7:0];
  end

  // lock only sets; reset is the sole way back
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      lock     <= 1'b0;
      slow_sel <= 1'b0;
    end else if (wr_go && idx == `FPR_IDX_CTRL) begin
      lock     <= lock | pwdata_i[`FPR_LOCK_BIT];
      if (!lock)
        slow_sel <= pwdata_i[`FPR_SLOW_BIT];
    end
  end

  // source, minimum and manual duty per output
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCH; i++)
        src_reg[i] <= fpr_src_t'(`FPR_SRC_RST);
      min_reg <= {NCH{`FPR_MIN_RST}};
      man_reg <= {NCH{`FPR_MAN_RST}};
    end else if (wr_go) begin
      for (int i = 0; i < NCH; i++) begin
        if (idx == 7'(`FPR_IDX_SRC0 + i))
          src_reg[i] <= fpr_src_t'(pwdata_i[2:0]);
        if (idx == 7'(`FPR_IDX_MIN0 + i))
          min_reg[i] <= pwdata_i[7:0];
        if (idx == 7'(`FPR_IDX_MAN0 + i))
          man_reg[i] <= pwdata_i[7:0];
      end
    end
  end

  // target duty from the chosen source, with the floor below threshold
  always_comb begin
    logic [7:0] val;
    logic       below;
    logic       autom;
    val   = 8'h00;
    below = 1'b0;
    autom = 1'b0;
    next_target = '0;
    for (int i = 0; i < NCH; i++) begin
      autom = 1'b1;
      case (src_reg[i])
        FPR_SRC_REMOTE1: begin
          val   = auto_duty_i[0];
          below = below_min_i[0];
        end
        FPR_SRC_LOCAL: begin
          val   = auto_duty_i[1];
          below = below_min_i[1];
        end
        FPR_SRC_REMOTE2: begin
          val   = auto_duty_i[2];
          below = below_min_i[2];
        end
        FPR_SRC_MAX_LR: begin
          val   = (auto_duty_i[1] > auto_duty_i[2]) ?
                  auto_duty_i[1] : auto_duty_i[2];
          below = below_min_i[1] && below_min_i[2];
        end
        FPR_SRC_MAX_ALL: begin
          val   = (auto_duty_i[1] > auto_duty_i[2]) ?
                  auto_duty_i[1] : auto_duty_i[2];
          val   = (auto_duty_i[0] > val) ? auto_duty_i[0] : val;
          below = &below_min_i;
        end
        FPR_SRC_FULL: begin
          autom = 1'b0;
          val   = 8'hFF;
          below = 1'b0;
        end
        FPR_SRC_MANUAL: begin
          autom = 1'b0;
          val   = man_reg[i];
          below = 1'b0;
        end
        default: begin                            // disabled output
          autom = 1'b0;
          val   = 8'h00;
          below = 1'b0;
        end
      endcase
      // floor bit per output selects zero or minimum duty
      if (autom && below)
        next_target[i] = remote1_ramp_rate[`FPR_FLOOR_LSB + i] ? min_reg[i] : 8'h00;
      else
        next_target[i] = val;
    end
  end

  // registered target keeps the ramp compare off the input paths
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      target <= '0;
    else
      target <= next_target;
  end

  // ramp slot length: sweep time over full-scale duty steps
  fpr_tick #(
    .DIV_A (SLOT_FAST_CYC),
    .DIV_B (SLOT_SLOW_CYC)
  ) u_slot (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_b_i   (slow_sel),
    .tick_o    (slot_tick)
  );

  // base step rate: twice the top low rate times the period steps
  fpr_tick #(
    .DIV_A (BASE_CYC),
    .DIV_B (BASE_CYC)
  ) u_base (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_b_i   (1'b0),
    .tick_o    (base_tick)
  );

  // fast-drive step rate for 4-wire fans
  fpr_tick #(
    .DIV_A (HF_CYC),
    .DIV_B (HF_CYC)
  ) u_hf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_b_i   (1'b0),
    .tick_o    (hf_tick)
  );

  // one drive per output; output n follows rate register n
  for (genvar g = 0; g < NCH; g++) begin : g_out
    fpr_cfg_if cif ();
    assign cif.rate_sel  = rate_reg[g][`FPR_RATE_LSB +: 3];
    assign cif.fast_sel  = rate_reg[g][`FPR_FAST_BIT];
    // smoothing only for remote-1 governed outputs with enable set
    assign cif.smooth_on = remote1_ramp_rate[`FPR_SMOOTH_BIT] &&
                           (src_reg[g] == FPR_SRC_REMOTE1);
    assign cif.ramp_code = remote1_ramp_rate[`FPR_RAMP_LSB +: 3];
    assign cif.slot_tick = slot_tick;
    assign cif.base_tick = base_tick;
    assign cif.hf_tick   = hf_tick;
    assign cif.target    = target[g];
    assign duty[g]       = cif.duty;

    fpr_drive #(
      .CNT_W (8)
    ) u_drive (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .cfg       (cif.drive),
      .pwm_o     (pwm[g])
    );
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fan_drive_one_o   <= 1'b0;
      fan_drive_two_o   <= 1'b0;
      fan_drive_three_o <= 1'b0;
      speed_sync_o      <= 1'b0;
      lock_o            <= 1'b0;
    end else begin
      fan_drive_one_o   <= pwm[0];
      fan_drive_two_o   <= pwm[1];
      fan_drive_three_o <= pwm[2];
      speed_sync_o      <= remote1_ramp_rate[`FPR_SYNC_BIT];
      lock_o            <= lock;
    end
  end

  // slope span per channel for the upstream duty calculator
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCH; i++)
        range_span_o[i] <= fpr_span_cdeg(
          4'(`FPR_RATE_RST >> `FPR_RANGE_LSB));
    end else begin
      for (int i = 0; i < NCH; i++)
        range_span_o[i] <= fpr_span_cdeg(rate_reg[i][`FPR_RANGE_LSB +: 4]);
    end
  end
endmodule

// *** sim/fpr_top_checker.sv ***
// assertions on the apb answer and on settings frozen by the lock
// assumes binding onto fpr_top with its default address width
`timescale 1ns/1ps
module fpr_top_checker #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              resetn_i,
  // apb
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  // settings
  input wire logic              speed_sync_o,
  input wire logic [2:0][15:0]  range_span_o,
  input wire logic              lock_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // accepted writes that may move a setting; locked ones never do
  wire logic wr_ok = pready_o && pwrite_i && !pslverr_o && !lock_o;
  wire logic wr_sync = wr_ok && paddr_i == 10'h188;
  wire logic wr_rate = wr_ok && paddr_i inside {10'h17C, 10'h180, 10'h184};

  a_ready_late: assert property (psel_i && !penable_i |=>
    !pready_o ##1 pready_o) else $error("answer not after one wait");
  a_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_align: assert property (pready_o && paddr_i[1:0] != 2'h0
    |-> pslverr_o) else $error("unaligned access not refused");
  a_err_high: assert property (pready_o && paddr_i[ADDR_W-1]
    |-> pslverr_o) else $error("address above map not refused");
  a_err_mapped: assert property (pready_o && paddr_i == 10'h17C
    |-> !pslverr_o) else $error("mapped register refused");
  a_err_alone: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rd_upper: assert property (pready_o && !pwrite_i
    |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  a_lock_stays: assert property (lock_o |=> lock_o)
    else $error("lock cleared without reset");
  a_sync_cause: assert property ($changed(speed_sync_o)
    |-> $past(wr_sync, 1) || $past(wr_sync, 2))
    else $error("sync moved without an accepted write");
  a_span_cause: assert property ($changed(range_span_o)
    |-> $past(wr_rate, 1) || $past(wr_rate, 2))
    else $error("span moved without an accepted write");

  c_refused: cover property (pready_o && pslverr_o);
  c_locked_write: cover property (pready_o && pwrite_i && lock_o);
  c_sync_on: cover property ($rose(speed_sync_o));
endmodule

bind fpr_top fpr_top_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .speed_sync_o(speed_sync_o), .range_span_o(range_span_o),
  .lock_o(lock_o));

// *** sim/fpr_fan_model.sv ***
// behavioural fan: times the drive waveform between rising edges
// assumes the drive is a plain level sampled on the system clock
`timescale 1ns/1ps
module fpr_fan_model (
  // clock
  input  wire logic   clk_sys_i,
  // drive from the block
  input  wire logic   pwm_i,
  // measured period in clock cycles and its strobe
  output logic [15:0] period_o,
  output logic        edge_o
);
  logic        prev = 1'b0;
  logic [15:0] cnt  = 16'h0000;
  // a fan sees only the waveform, so time it edge to edge
  always_ff @(posedge clk_sys_i) begin
    prev   <= pwm_i;
    edge_o <= pwm_i && !prev;
    if (pwm_i && !prev) begin
      period_o <= cnt;
      cnt      <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the fan drive rate and smoothing block
// assumes the design, checker and fan model are compiled first
`timescale 1ns/1ps
module testbench;
  import fpr_pkg::*;
  typedef struct {
    logic        e;
    logic [31:0] m;
    logic [31:0] v;
  } fpr_exp_t;
  localparam int          BASE = 2;
  localparam int          HF   = 1;
  localparam logic [31:0] ALL  = 32'hFFFFFFFF;
  logic            clk_sys_i = 1'b0;
  logic            resetn_i  = 1'b0;
  logic            psel      = 1'b0;
  logic            pen       = 1'b0;
  logic            pwr       = 1'b0;
  logic [9:0]      paddr     = 10'h000;
  logic [31:0]     pwdata    = 32'h0;
  logic [2:0][7:0] duty      = '0;
  logic [2:0]      below     = 3'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            perr;
  logic [2:0]      fan;
  logic            sync;
  logic [2:0][15:0] span;
  logic            lock;
  logic [2:0]      fe;
  logic [15:0]     fp [3];
  logic [31:0]     rdv;
  fpr_exp_t        q [$];
  int              err_count = 0;
  int              n_tests   = 0;
  // span in hundredths of a degree, rate dividers, ramp steps
  int rng [16] = '{200, 250, 333, 400, 500, 667, 800, 1000, 1333,
                   1600, 2000, 2667, 3200, 4000, 5333, 8000};
  int dv [8]   = '{16, 12, 8, 6, 5, 4, 3, 2};
  int stp [8]  = '{1, 2, 3, 4, 8, 12, 24, 48};

  always #4 clk_sys_i = ~clk_sys_i;

  // short counts keep slots and pwm periods within the run
  fpr_top #(.SLOT_FAST_CYC(20), .SLOT_SLOW_CYC(28), .BASE_CYC(BASE),
            .HF_CYC(HF)) uut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .auto_duty_i(duty), .below_min_i(below),
    .fan_drive_one_o(fan[0]), .fan_drive_two_o(fan[1]),
    .fan_drive_three_o(fan[2]), .speed_sync_o(sync),
    .range_span_o(span), .lock_o(lock));

  for (genvar i = 0; i < 3; i++) begin : g_fan
    fpr_fan_model u_fan (.clk_sys_i(clk_sys_i), .pwm_i(fan[i]),
                         .period_o(fp[i]), .edge_o(fe[i]));
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [9:0] ba(input logic [6:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_count++;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    q.push_back('{1'b0, 32'h0, 32'h0});
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] m,
                    input logic [31:0] v, input logic e = 1'b0);
    q.push_back('{e, m, v});
    apb(1'b0, a, 32'h0);
  endtask

  // drain edges launched before the change, then skip the mixed period
  task automatic per(input int i, input int p);
    int n;
    w(8);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (fe[i] !== 1'b1 && n < 20000);
    end
    chk("period", 32'(p), 32'(fp[i]));
  endtask

  // every answer is matched against the oldest noted expectation
  always @(posedge clk_sys_i) begin
    fpr_exp_t x;
    if (pready === 1'b1) begin
      x = q.pop_front();
      rdv = prdata;
      chk("pslverr", 32'(x.e), 32'(perr));
      chk("prdata", x.v & x.m, prdata & x.m);
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    err_count++;
    test_done();
  end

  initial begin
    int         c;
    logic [7:0] mv;
    c = $urandom(67);
    w(5);
    resetn_i <= 1'b1;
    chk("span", 32'h0C80, 32'(span[1]));
    for (c = 0; c < 3; c++) rd(ba(7'h5F + 7'(c)), ALL, 32'hC4);
    rd(ba(7'h62), ALL, 32'h0);
    rd(10'h3FC, 32'h0, 32'h0, 1'b1);
    rd(10'h17D, 32'h0, 32'h0, 1'b1);
    rd(ba(7'h10), 32'h0, 32'h0, 1'b1);
    // every span code
    for (c = 0; c < 16; c++) begin
      wr(ba(7'h61), 32'(c * 16 + 4));
      w(3);
      chk("span", 32'(rng[c]), 32'(span[2]));
    end
    wr(ba(7'h62), 32'h10);
    w(3);
    chk("sync", 32'h1, 32'(sync));
    // each output on its own channel, then below threshold
    for (c = 0; c < 3; c++) begin
      mv = 8'($urandom_range(254, 1));
      wr(ba(7'h71 + 7'(c)), 32'(c));
      wr(ba(7'h74 + 7'(c)), 32'(mv));
      duty[c] <= 8'hFF;
      w(8);
      rd(ba(7'h7A + 7'(c)), ALL, 32'hFF);
      chk("fan_high", 32'h1, 32'(fan[c]));
      below[c] <= 1'b1;
      wr(ba(7'h62), 32'h0);
      w(8);
      rd(ba(7'h7A + 7'(c)), ALL, 32'h0);
      wr(ba(7'h62), 32'(8'h20 << c));
      w(8);
      rd(ba(7'h7A + 7'(c)), ALL, 32'(mv));
    end
    below <= 3'h0;
    // ramp from zero for every step code; 60 cycles is three slots
    for (c = 0; c < 8; c++) begin
      wr(ba(7'h62), 32'h0);
      duty[0] <= 8'h00;
      w(8);
      wr(ba(7'h62), 32'(8 + c));
      duty[0] <= 8'hFF;
      w(60);
      rd(ba(7'h7A), 32'h0, 32'h0);
      w(1);
      chk("ramp_step", 32'h0, rdv % stp[c]);
      chk("ramp_span", 32'h1, 32'(rdv > 0 && rdv <= 5 * stp[c]));
    end
    wr(ba(7'h62), 32'h0);
    w(8);
    rd(ba(7'h7A), ALL, 32'hFF);
    // all low rates, then fast drive with rate code zero
    duty[0] <= 8'h80;
    for (c = 0; c < 9; c++) begin
      wr(ba(7'h5F), c < 8 ? 32'(8'hC0 + c) : 32'hC8);
      per(0, c < 8 ? 256 * BASE * dv[c] : 256 * HF);
    end
    // lock freezes rate and acoustic settings
    wr(ba(7'h5F), 32'h37);
    wr(ba(7'h70), 32'h3);
    wr(ba(7'h5F), 32'h99);
    wr(ba(7'h70), 32'h0);
    wr(ba(7'h62), 32'h10);
    w(3);
    chk("lock", 32'h1, 32'(lock));
    chk("sync", 32'h0, 32'(sync));
    rd(ba(7'h5F), ALL, 32'h37);
    rd(ba(7'h70), ALL, 32'h3);
    chk("span", 32'(rng[3]), 32'(span[0]));
    test_done();
  end
endmodule
